// >>> core/pin_cfg_pkg.sv
`default_nettype none
package pin_cfg_pkg;
  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [7:0] PIN_FUNCTION_CONFIG_ADDR = 8'h06;
  localparam logic [15:0] PIN_FUNCTION_CONFIG_RST = 16'h0800;
  localparam int AUX_OUTPUT_ENABLE_BIT = 13;
  localparam int EXT_MUX_CONTROL_BIT = 12;
  localparam int SYNC_ENABLE_BIT = 11;
  localparam int ERR_MODE_HI_BIT = 10;
  localparam int ERR_MODE_LO_BIT = 9;
  localparam int ERROR_PIN_LEVEL_BIT = 8;
  localparam logic [15:0] WRITE_MASK = 16'h2F00;
  // ********************************************************
  // Error pin modes and sequencing limits
  // ********************************************************
  localparam logic [1:0] ERR_MODE_OFF = 2'h0;
  localparam logic [1:0] ERR_MODE_OUT_OD = 2'h1;
  localparam logic [1:0] ERR_MODE_IN = 2'h2;
  localparam logic [1:0] ERR_MODE_GPO = 2'h3;
  localparam int MUX_CHANNELS = 16;
  localparam int TOTAL_CHANNELS = 128;
  localparam logic [15:0] SETTLE_DELAY_RST = 16'h0000;
  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_WAIT_SYNC, ST_CONVERT}
    seq_state_t;
endpackage
`default_nettype wire

// >>> core/sync_gate.sv
`default_nettype none
// Decides when a conversion may begin after a channel switch.
module sync_gate
  import pin_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic alt_mode,
  input wire logic switch_due,
  input wire logic sync_level,
  // Result
  output logic start_ff
);
  typedef struct packed {
    logic pending;
    logic start;
  } gate_t;
  gate_t cur_ff, nxt_cur;
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.start = 1'b0;
    if (switch_due || cur_ff.pending) begin
      // RULE_07 hold while low
      if (alt_mode && !sync_level) begin
        nxt_cur.pending = 1'b1;
      end else begin
        // RULE_08 start on high
        nxt_cur.pending = 1'b0;
        nxt_cur.start = 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end
  assign start_ff = cur_ff.start;
endmodule
`default_nettype wire

// >>> core/pin_function_ctrl.sv
// Operation
// RULE_01 - Auxiliary outputs driven only while bit 13 is one.
// RULE_02 - Bit 12 drives four pins as mux select following sequencer; here bit 12 is outside WRITE_MASK and stays zero.
// RULE_03 - Analog pair stays per channel; sixteen channels sequenced per pass.
// RULE_04 - Host reselects the input pair after each sixteen channel pass.
// RULE_05 - Programmable settling delay after every channel switch.
// RULE_06 - Sync enabled and pin low holds converter and filter in reset.
// RULE_07 - Alternate sync: low pin at switch time blocks next conversion.
// RULE_08 - Alternate sync: raising the pin starts the pending conversion.
// RULE_09 - Two-bit error pin mode at bits 10:9, reset zero.
// RULE_10 - Mode 10: active-low input, ORed into error flag, level readable.
// RULE_11 - Mode 11: error pin is output driven from the level bit.
`default_nettype none
module pin_function_ctrl
  import pin_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Sequencer side
  input wire logic seq_step,
  input wire logic [3:0] seq_channel,
  input wire logic multi_channel,
  input wire logic alternate_sync_select,
  input wire logic [15:0] settle_delay,
  input wire logic other_error,
  // Pins
  input wire logic sync_n,
  input wire logic error_pin_in,
  output logic error_pin_out,
  output logic error_pin_oe,
  output logic gp_pin_a,
  output logic gp_pin_a_oe,
  output logic gp_pin_b,
  output logic gp_pin_b_oe,
  output logic aux_out_a,
  output logic aux_out_b,
  output logic aux_out_oe,
  // Converter control
  output logic conv_reset,
  output logic conv_start,
  output logic adc_error
);
  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] rdata;
    seq_state_t st;
    logic [15:0] cnt;
    logic [3:0] sel;
    logic [3:0] mux_pins;
    logic mux_oe;
    logic aux_oe;
    logic conv_reset;
    logic conv_start;
    logic err_out;
    logic err_oe;
    logic adc_error;
  } ctrl_t;
  ctrl_t cur_ff, nxt_cur;
  // ********************************************************
  // Helpers
  // ********************************************************
  // True for a strobe aimed at the one register of this block.
  function automatic logic cfg_hit(input logic strobe,
    input logic [7:0] addr);
    return strobe && addr == PIN_FUNCTION_CONFIG_ADDR;
  endfunction
  // Read-only and reserved bits keep their value whatever is written.
  function automatic logic [15:0] merge_write(input logic [15:0] cfg,
    input logic [15:0] wdata);
    return (wdata & WRITE_MASK) | (cfg & ~WRITE_MASK);
  endfunction
  // Select lines are held low while the mux function is off, so a
  // released pin never carries stale channel bits.
  function automatic logic [3:0] mux_select(input logic [15:0] cfg,
    input logic [3:0] sel);
    return cfg[EXT_MUX_CONTROL_BIT] ? sel : 4'h0;
  endfunction
  logic gate_start;
  logic [1:0] err_mode;
  logic sync_on;
  assign err_mode = cur_ff.cfg[ERR_MODE_HI_BIT:ERR_MODE_LO_BIT];
  assign sync_on = cur_ff.cfg[SYNC_ENABLE_BIT];
  // ********************************************************
  // Start gate
  // ********************************************************
  sync_gate u_gate (
    .clk(clk),
    .rst_n(rst_n),
    .alt_mode(alternate_sync_select && multi_channel && sync_on),
    .switch_due(cur_ff.st == ST_SETTLE && cur_ff.cnt == 16'h0000),
    .sync_level(sync_n),
    .start_ff(gate_start)
  );
  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.conv_start = 1'b0;
    // ********************************************************
    // Register write and read port
    // ********************************************************
    if (cfg_hit(reg_wr, reg_addr)) begin
      // RULE_09 writable mode field
      nxt_cur.cfg = merge_write(cur_ff.cfg, reg_wdata);
    end
    // The pin wins over a write in the same cycle, so software never
    // reads back a level that the pin no longer shows.
    // RULE_10 level bit follows pin
    if (err_mode == ERR_MODE_IN) begin
      nxt_cur.cfg[ERROR_PIN_LEVEL_BIT] = error_pin_in;
    end
    if (cfg_hit(reg_rd, reg_addr)) begin
      nxt_cur.rdata = cur_ff.cfg;
    end else if (reg_rd) begin
      nxt_cur.rdata = 16'h0000;
    end
    // ********************************************************
    // Error pin
    // ********************************************************
    // RULE_10 inverted pin into flag
    nxt_cur.adc_error = other_error ||
      (err_mode == ERR_MODE_IN && !error_pin_in);
    unique case (err_mode)
      ERR_MODE_OFF, ERR_MODE_IN: begin
        nxt_cur.err_oe = 1'b0;
        nxt_cur.err_out = 1'b0;
      end
      ERR_MODE_OUT_OD: begin
        // An open-drain net only ever pulls low, so the data is zero.
        nxt_cur.err_oe = other_error;
        nxt_cur.err_out = 1'b0;
      end
      ERR_MODE_GPO: begin
        // RULE_11 general output
        nxt_cur.err_oe = 1'b1;
        nxt_cur.err_out = cur_ff.cfg[ERROR_PIN_LEVEL_BIT];
      end
    endcase
    // ********************************************************
    // Auxiliary and multiplexer select pins
    // ********************************************************
    // RULE_01 aux enable
    nxt_cur.aux_oe = cur_ff.cfg[AUX_OUTPUT_ENABLE_BIT] ||
      cur_ff.cfg[EXT_MUX_CONTROL_BIT];
    // RULE_02 mux select drive
    nxt_cur.mux_oe = cur_ff.cfg[EXT_MUX_CONTROL_BIT];
    nxt_cur.mux_pins = mux_select(cur_ff.cfg, cur_ff.sel);
    // ********************************************************
    // Sync gating and channel sequencer
    // ********************************************************
    // Alternate mode keeps the filter running; the gate holds the
    // next start instead of resetting anything.
    // RULE_06 plain sync reset
    nxt_cur.conv_reset = sync_on && !sync_n &&
      !(alternate_sync_select && multi_channel);
    // A step that comes while a switch still settles or waits is dropped,
    // so the select lines never move under a pending conversion.
    unique case (cur_ff.st)
      ST_IDLE, ST_CONVERT: begin
        if (seq_step) begin
          // RULE_03 sixteen way select
          nxt_cur.sel = seq_channel;
          // RULE_05 settle delay
          nxt_cur.cnt = settle_delay;
          nxt_cur.st = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (cur_ff.cnt != 16'h0000) begin
          nxt_cur.cnt = cur_ff.cnt - 16'h0001;
        end else begin
          nxt_cur.st = ST_WAIT_SYNC;
        end
      end
      ST_WAIT_SYNC: begin
        if (gate_start) begin
          nxt_cur.conv_start = 1'b1;
          nxt_cur.st = ST_CONVERT;
        end
      end
    endcase
    if (nxt_cur.conv_reset) begin
      nxt_cur.conv_start = 1'b0;
    end
  end
  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_ff <= '0;
      cur_ff.cfg <= PIN_FUNCTION_CONFIG_RST;
      cur_ff.st <= ST_IDLE;
    end else begin
      cur_ff <= nxt_cur;
    end
  end
  // ********************************************************
  // Outputs
  // ********************************************************
  assign reg_rdata = cur_ff.rdata;
  assign gp_pin_a = cur_ff.mux_pins[0];
  assign gp_pin_b = cur_ff.mux_pins[1];
  assign aux_out_a = cur_ff.mux_pins[2];
  assign aux_out_b = cur_ff.mux_pins[3];
  assign gp_pin_a_oe = cur_ff.mux_oe;
  assign gp_pin_b_oe = cur_ff.mux_oe;
  assign aux_out_oe = cur_ff.aux_oe;
  assign error_pin_out = cur_ff.err_out;
  assign error_pin_oe = cur_ff.err_oe;
  assign conv_reset = cur_ff.conv_reset;
  assign conv_start = cur_ff.conv_start;
  assign adc_error = cur_ff.adc_error;
endmodule
`default_nettype wire

// >>> verification/pin_cfg_chk.sv
`default_nettype none
module pin_cfg_chk
  import pin_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Pins and converter control
  input wire logic sync_n,
  input wire logic other_error,
  input wire logic gp_pin_a_oe,
  input wire logic aux_out_oe,
  input wire logic conv_reset,
  input wire logic conv_start,
  input wire logic adc_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_aux_enable:
  assert property (reg_wr && reg_addr == PIN_FUNCTION_CONFIG_ADDR
    ##1 !reg_wr |=> aux_out_oe ==
    $past(reg_wdata[AUX_OUTPUT_ENABLE_BIT], 2)) else $error("aux enable");
  chk_mux_idle:
  assert property (!gp_pin_a_oe) else $error("mux select driven");
  chk_fixed_bits:
  assert property (reg_rd |=> !reg_rdata[12] && reg_rdata[15:14] == 2'h0)
    else $error("fixed bits set");
  chk_unmapped_read:
  assert property (reg_rd && reg_addr != PIN_FUNCTION_CONFIG_ADDR |=>
    reg_rdata == 16'h0000) else $error("unmapped read not zero");
  chk_sync_hold:
  assert property (conv_reset |-> !$past(sync_n))
    else $error("reset without low sync");
  chk_reset_blocks:
  assert property (conv_reset |-> !conv_start) else $error("start in reset");
  chk_start_pulse:
  assert property (conv_start |=> !conv_start) else $error("start too long");
  chk_error_or:
  assert property (other_error [*2] |=> adc_error) else $error("error lost");
  cover property (conv_start);
  cover property (conv_reset);
  cover property (aux_out_oe);
endmodule
bind pin_function_ctrl pin_cfg_chk u_pin_cfg_chk (.clk, .rst_n, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .sync_n, .other_error,
  .gp_pin_a_oe, .aux_out_oe, .conv_reset, .conv_start, .adc_error);
`default_nettype wire

// >>> verification/ext_error_line.sv
`default_nettype none
// Error net outside the device, pulled up; a fault pulls it low.
module ext_error_line (
  // Device side
  input wire logic error_pin_oe,
  input wire logic error_pin_out,
  // Far side
  input wire logic fault,
  output logic error_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  assign error_pin_in = !(error_pin_oe && !error_pin_out) && !fault;
endmodule
`default_nettype wire

// >>> verification/pin_function_ctrl_bench.sv
`default_nettype none
module pin_function_ctrl_bench
  import pin_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, seq_step = 0;
  logic multi_channel = 0, alternate_sync_select = 0, sync_n = 1;
  logic other_error = 0, fault = 0, error_pin_in;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, settle_delay = 16'h0003, reg_rdata;
  logic [3:0] seq_channel = 4'h0;
  logic error_pin_out, error_pin_oe, gp_pin_a, gp_pin_a_oe, gp_pin_b;
  logic gp_pin_b_oe, aux_out_a, aux_out_b, aux_out_oe, conv_reset;
  logic conv_start, adc_error;
  int miscompares = 0, check_count = 0;
  pin_function_ctrl u_pin_function_ctrl (.clk, .rst_n, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .seq_step, .seq_channel,
    .multi_channel, .alternate_sync_select, .settle_delay, .other_error,
    .sync_n, .error_pin_in, .error_pin_out, .error_pin_oe, .gp_pin_a,
    .gp_pin_a_oe, .gp_pin_b, .gp_pin_b_oe, .aux_out_a, .aux_out_b,
    .aux_out_oe, .conv_reset, .conv_start, .adc_error);
  ext_error_line u_ext_error_line (.error_pin_oe, .error_pin_out, .fault,
    .error_pin_in);
  initial forever #4 clk = ~clk;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] d);
    @(posedge clk);
    reg_addr <= PIN_FUNCTION_CONFIG_ADDR;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    cmp(reg_rdata, exp);
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Counts start pulses; a step is launched first when asked to.
  task automatic watch(input logic go, input int span, output int first,
    output int hits);
    first = 0;
    hits = 0;
    @(posedge clk);
    seq_step <= go;
    @(posedge clk);
    seq_step <= 1'b0;
    for (int k = 1; k <= span; k++) begin
      @(negedge clk);
      if (conv_start === 1'b1) begin
        if (hits == 0) first = k;
        hits++;
      end
    end
  endtask
  task automatic end_sim;
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_regs;
    rd(PIN_FUNCTION_CONFIG_ADDR, PIN_FUNCTION_CONFIG_RST);
    rd(8'h07, 16'h0000);
    wr(16'hFFFF);
    rd(PIN_FUNCTION_CONFIG_ADDR, 16'h2F00);
    cmp(aux_out_oe, 1'b1);
    cmp({error_pin_oe, error_pin_out}, 2'h3);
    wr(16'h0600);
    cmp({error_pin_oe, error_pin_out}, 2'h2);
    cmp(aux_out_oe, 1'b0);
  endtask
  task automatic t_err_in;
    wr(16'h0400);
    @(posedge clk);
    fault <= 1'b1;
    hold(3);
    rd(PIN_FUNCTION_CONFIG_ADDR, 16'h0400);
    cmp(adc_error, 1'b1);
    @(posedge clk);
    fault <= 1'b0;
    other_error <= 1'b1;
    hold(3);
    rd(PIN_FUNCTION_CONFIG_ADDR, 16'h0500);
    cmp(adc_error, 1'b1);
    @(posedge clk);
    other_error <= 1'b0;
    hold(2);
    cmp(adc_error, 1'b0);
  endtask
  task automatic t_sync;
    wr(16'h0800);
    @(posedge clk);
    sync_n <= 1'b0;
    hold(3);
    cmp({conv_reset, conv_start}, 2'h2);
    @(posedge clk);
    sync_n <= 1'b1;
    hold(2);
    cmp(conv_reset, 1'b0);
  endtask
  task automatic t_alt;
    int first, hits, base;
    @(posedge clk);
    alternate_sync_select <= 1'b1;
    multi_channel <= 1'b1;
    watch(1'b1, 12, first, hits);
    cmp(first > 3, 1'b1);
    cmp(16'(hits), 16'h0001);
    base = first;
    @(posedge clk);
    settle_delay <= 16'h0008;
    watch(1'b1, 16, first, hits);
    cmp(16'(first - base), 16'h0005);
    @(posedge clk);
    settle_delay <= 16'h0003;
    sync_n <= 1'b0;
    watch(1'b1, 20, first, hits);
    cmp(16'(hits), 16'h0000);
    cmp(conv_reset, 1'b0);
    @(posedge clk);
    sync_n <= 1'b1;
    watch(1'b0, 6, first, hits);
    cmp(16'(hits), 16'h0001);
  endtask
  task automatic t_mux;
    int first, hits;
    for (int k = 0; k < MUX_CHANNELS; k++) begin
      @(posedge clk);
      seq_channel <= 4'(k);
      watch(1'b1, 8, first, hits);
      cmp(16'(hits), 16'h0001);
      cmp({gp_pin_a, gp_pin_b, aux_out_a, aux_out_b}, 4'h0);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_err_in;
    t_sync;
    t_alt;
    t_mux;
    end_sim;
  end
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    end_sim;
  end
endmodule
`default_nettype wire
